//--- shared/fpod_map.vh
// Constants for the escape opcode decoder: patterns, operation codes, classes, operand types
`ifndef FPOD_MAP_VH
`define FPOD_MAP_VH

// ****************************************
// Opcode fields
// ****************************************
`define FPOD_ESCAPE          5'h1B
`define FPOD_MOD_REGISTER    2'h3
`define FPOD_HI5_LOAD        5'h18
`define FPOD_HI5_EXCHANGE    5'h19
`define FPOD_HI5_STORE       5'h1A
`define FPOD_HI5_STORE_POP   5'h1B
`define FPOD_HI5_UCOM        5'h1C
`define FPOD_HI5_UCOM_POP    5'h1D
`define FPOD_HI5_ADD         5'h18
`define FPOD_HI5_MUL         5'h19
`define FPOD_HI4_SUB         4'hE
`define FPOD_HI4_DIV         4'hF

// ****************************************
// Operation codes
// ****************************************
`define FPOD_OP_INVALID                6'h00
`define FPOD_OP_LOAD_TO_TOP            6'h01
`define FPOD_OP_STORE_TOP              6'h02
`define FPOD_OP_STORE_TOP_POP          6'h03
`define FPOD_OP_EXCHANGE_TOP           6'h04
`define FPOD_OP_ORDERED_COMPARE        6'h05
`define FPOD_OP_ORDERED_COMPARE_POP    6'h06
`define FPOD_OP_ORDERED_COMPARE_POP2   6'h07
`define FPOD_OP_UNORDERED_COMPARE      6'h08
`define FPOD_OP_UNORDERED_COMPARE_POP  6'h09
`define FPOD_OP_UNORDERED_COMPARE_POP2 6'h0A
`define FPOD_OP_TEST_AGAINST_ZERO      6'h0B
`define FPOD_OP_EXAMINE_TOP            6'h0C
`define FPOD_OP_LOAD_CONST_ZERO        6'h0D
`define FPOD_OP_LOAD_CONST_ONE         6'h0E
`define FPOD_OP_LOAD_CONST_PI          6'h0F
`define FPOD_OP_LOAD_LOG2_TEN          6'h10
`define FPOD_OP_LOAD_LOG2_E            6'h11
`define FPOD_OP_LOAD_LOG10_TWO         6'h12
`define FPOD_OP_LOAD_LN_TWO            6'h13
`define FPOD_OP_ADD                    6'h14
`define FPOD_OP_SUBTRACT               6'h15
`define FPOD_OP_MULTIPLY               6'h16
`define FPOD_OP_DIVIDE                 6'h17
`define FPOD_OP_SQUARE_ROOT            6'h18
`define FPOD_OP_SCALE_BY_POWER         6'h19
`define FPOD_OP_PARTIAL_REMAINDER      6'h1A
`define FPOD_OP_STD_PARTIAL_REMAINDER  6'h1B
`define FPOD_OP_ROUND_INTEGER          6'h1C
`define FPOD_OP_SPLIT_EXPONENT         6'h1D
`define FPOD_OP_ABSOLUTE_VALUE         6'h1E
`define FPOD_OP_NEGATE_SIGN            6'h1F
`define FPOD_OP_PARTIAL_TANGENT        6'h20
`define FPOD_OP_PARTIAL_ARCTANGENT     6'h21
`define FPOD_OP_SINE                   6'h22
`define FPOD_OP_COSINE                 6'h23
`define FPOD_OP_SINE_COSINE            6'h24
`define FPOD_OP_EXP2_MINUS_ONE         6'h25
`define FPOD_OP_Y_LOG2_X               6'h26
`define FPOD_OP_Y_LOG2_X_PLUS_ONE      6'h27
`define FPOD_OP_INITIALISE_UNIT        6'h28
`define FPOD_OP_STORE_STATUS_WORD      6'h29
`define FPOD_OP_LOAD_CONTROL_WORD      6'h2A
`define FPOD_OP_STORE_CONTROL_WORD     6'h2B
`define FPOD_OP_CLEAR_EXCEPTIONS       6'h2C
`define FPOD_OP_STORE_ENVIRONMENT      6'h2D
`define FPOD_OP_LOAD_ENVIRONMENT       6'h2E
`define FPOD_OP_SAVE_FULL_STATE        6'h2F
`define FPOD_OP_RESTORE_FULL_STATE     6'h30
`define FPOD_OP_STACK_PTR_INCREMENT    6'h31
`define FPOD_OP_STACK_PTR_DECREMENT    6'h32
`define FPOD_OP_FREE_REGISTER          6'h33
`define FPOD_OP_NO_OPERATION           6'h34

// ****************************************
// Operation classes
// ****************************************
`define FPOD_CLASS_INVALID        3'h0
`define FPOD_CLASS_TRANSFER       3'h1
`define FPOD_CLASS_COMPARE        3'h2
`define FPOD_CLASS_CONSTANT       3'h3
`define FPOD_CLASS_ARITHMETIC     3'h4
`define FPOD_CLASS_TRANSCENDENTAL 3'h5
`define FPOD_CLASS_CONTROL        3'h6

// ****************************************
// Memory operand types (low four codes equal the memory_format field)
// ****************************************
`define FPOD_TYPE_REAL32  3'h0
`define FPOD_TYPE_INT32   3'h1
`define FPOD_TYPE_REAL64  3'h2
`define FPOD_TYPE_INT16   3'h3
`define FPOD_TYPE_INT64   3'h4
`define FPOD_TYPE_REAL80  3'h5
`define FPOD_TYPE_BCD     3'h6
`define FPOD_TYPE_NONE    3'h7

`endif

//--- design/fpod_reset_sync.v
// Two-stage release synchroniser for the active-low reset
module fpod_reset_sync (
  input  wire ref_clk_i,
  input  wire nrst_i,
  output wire nrst_sync_o
);
  reg stage_a;
  reg stage_b;

  // Assert at once, release only after two clean edges
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage_a <= 1'b0;
      stage_b <= 1'b0;
    end else begin
      stage_a <= 1'b1;
      stage_b <= stage_a;
    end
  end

  assign nrst_sync_o = stage_b;
endmodule // fpod_reset_sync

//--- design/fpod_field_split.v
// Splits a two-byte escape opcode into its encoding fields
`include "fpod_map.vh"
module fpod_field_split (
  input  wire [7:0] opcode_hi_i,
  input  wire [7:0] opcode_lo_i,
  output wire       escape_match_o,
  output wire [2:0] low_bits_o,
  output wire       register_form_o,
  output wire [2:0] reg_field_o,
  output wire [4:0] second_hi5_o,
  output wire [2:0] stack_register_index_o
);
  assign escape_match_o         = (opcode_hi_i[7:3] == `FPOD_ESCAPE);
  assign low_bits_o             = opcode_hi_i[2:0];
  // A mod of 11 never names memory, so it marks register or operand-less forms
  assign register_form_o        = (opcode_lo_i[7:6] == `FPOD_MOD_REGISTER);
  assign reg_field_o            = opcode_lo_i[5:3];
  assign second_hi5_o           = opcode_lo_i[7:3];
  assign stack_register_index_o = opcode_lo_i[2:0];
endmodule // fpod_field_split

//--- design/fpod_decoder.v
// Escape-prefixed coprocessor opcode decoder, top level
// Notes on behaviour
// - Only first bytes whose top five bits are 11011 are decoded.
// - Load to top: memory forms by format and reg 000, special wide types, 001 11000+i.
// - Store top: memory reg 010, or 101 then 11010 plus index.
// - Store and pop: memory reg 011, wide types reg 111/110, or 101 11011+i.
// - Exchange top with register: 001 then 11001 plus index.
// - Ordered compare reg 010 or 000 11010+i; with pop reg 011 or 000 11011+i.
// - Compare register one with top, double pop: 110 then 11011001.
// - Unordered compare 101 11100+i, pop 101 11101+i, double pop 010 11101001.
// - Test against zero 001 11100100; examine top 001 11100101.
// - Seven constant loads use low bits 001 with second bytes 11101000..11101110.
// - Add: memory reg 000, register form d P 0 then 11000 plus index.
// - Subtract and divide: memory reg 10R/11R, register 1110R/1111R; R reverses.
// - Multiply register form: d P 0 then 11001 plus index.
// - Square root, scale, remainders, round, split exponent under low bits 001.
// - Absolute value 001 11100001; sign inversion 001 11100000.
// - Tangent, arctangent, sine, cosine, sine-cosine under low bits 001.
// - Two-power minus one and the two logarithm forms under low bits 001.
// - Initialise 011 11100011, clear exceptions 011 11100010, status to accumulator 111 11100000.
// - Low bits 001 memory: reg 101,111,110,100 are control and environment moves.
// - Low bits 101 memory: reg 111 status store, 110 save, 100 restore.
// - Stack pointer increment, decrement, free register, and no-operation encodings.
// - Memory format 00 real32, 01 int32, 10 real64, 11 int16.
// - Direction bit picks destination; pop bit pops the top afterwards.
// - Reverse bit picks operand order, inverted when direction is one.
// - A second byte with top bits 11 is a register or operand-less form.
`include "fpod_map.vh"
module fpod_decoder (
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  input  wire       valid_i,
  input  wire [7:0] opcode_hi_i,
  input  wire [7:0] opcode_lo_i,
  output reg        valid_o,
  output reg        invalid_o,
  output reg  [5:0] op_o,
  output reg  [2:0] class_o,
  output reg        is_memory_o,
  output reg  [1:0] memory_format_o,
  output reg  [2:0] operand_type_o,
  output reg  [2:0] stack_register_index_o,
  output reg        direction_o,
  output reg  [1:0] pop_count_o,
  output reg        reverse_o,
  output reg        to_accumulator_o
);
  // ****************************************
  // Reset and field split
  // ****************************************
  wire       nrst_sync;
  wire       escape_match;
  wire [2:0] low_bits;
  wire       register_form;
  wire [2:0] reg_field;
  wire [4:0] second_hi5;
  wire [2:0] stack_index;
  fpod_reset_sync u_reset_sync (
    .ref_clk_i   (ref_clk_i),
    .nrst_i      (nrst_i),
    .nrst_sync_o (nrst_sync)
  );
  fpod_field_split u_field_split (
    .opcode_hi_i            (opcode_hi_i),
    .opcode_lo_i            (opcode_lo_i),
    .escape_match_o         (escape_match),
    .low_bits_o             (low_bits),
    .register_form_o        (register_form),
    .reg_field_o            (reg_field),
    .second_hi5_o           (second_hi5),
    .stack_register_index_o (stack_index)
  );

  // ****************************************
  // Operation decode
  // ****************************************
  function [2:0] class_of;
    input [5:0] op;
    begin
      if (op == `FPOD_OP_INVALID)
        class_of = `FPOD_CLASS_INVALID;
      else if (op < `FPOD_OP_ORDERED_COMPARE)
        class_of = `FPOD_CLASS_TRANSFER;
      else if (op < `FPOD_OP_LOAD_CONST_ZERO)
        class_of = `FPOD_CLASS_COMPARE;
      else if (op < `FPOD_OP_ADD)
        class_of = `FPOD_CLASS_CONSTANT;
      else if (op < `FPOD_OP_PARTIAL_TANGENT)
        class_of = `FPOD_CLASS_ARITHMETIC;
      else if (op < `FPOD_OP_INITIALISE_UNIT)
        class_of = `FPOD_CLASS_TRANSCENDENTAL;
      else
        class_of = `FPOD_CLASS_CONTROL;
    end
  endfunction
  reg [5:0] next_op;
  reg [2:0] next_type;
  reg [1:0] next_pop;
  reg       next_dir;
  reg       next_rev;
  reg       next_acc;
  reg       next_uses_index;
  always @* begin
    next_op         = `FPOD_OP_INVALID;
    next_type       = `FPOD_TYPE_NONE;
    next_pop        = 2'h0;
    next_dir        = 1'b0;
    next_rev        = 1'b0;
    next_acc        = 1'b0;
    next_uses_index = 1'b0;
    if (!register_form) begin
      next_type = {1'b0, low_bits[2:1]};
      if (low_bits[0]) begin
        case (reg_field)
          3'h0: next_op = `FPOD_OP_LOAD_TO_TOP;
          3'h2: next_op = `FPOD_OP_STORE_TOP;
          3'h3: begin
            next_op  = `FPOD_OP_STORE_TOP_POP;
            next_pop = 2'h1;
          end
          default: next_op = `FPOD_OP_INVALID;
        endcase
        // Wide types and control moves reuse format codes, so they override
        case ({low_bits, reg_field})
          6'h3D: begin
            next_op   = `FPOD_OP_LOAD_TO_TOP;
            next_type = `FPOD_TYPE_INT64;
          end
          6'h1D: begin
            next_op   = `FPOD_OP_LOAD_TO_TOP;
            next_type = `FPOD_TYPE_REAL80;
          end
          6'h3C: begin
            next_op   = `FPOD_OP_LOAD_TO_TOP;
            next_type = `FPOD_TYPE_BCD;
          end
          6'h3F: begin
            next_op   = `FPOD_OP_STORE_TOP_POP;
            next_type = `FPOD_TYPE_INT64;
            next_pop  = 2'h1;
          end
          6'h1F: begin
            next_op   = `FPOD_OP_STORE_TOP_POP;
            next_type = `FPOD_TYPE_REAL80;
            next_pop  = 2'h1;
          end
          6'h3E: begin
            next_op   = `FPOD_OP_STORE_TOP_POP;
            next_type = `FPOD_TYPE_BCD;
            next_pop  = 2'h1;
          end
          6'h0D: next_op = `FPOD_OP_LOAD_CONTROL_WORD;
          6'h0F: next_op = `FPOD_OP_STORE_CONTROL_WORD;
          6'h0E: next_op = `FPOD_OP_STORE_ENVIRONMENT;
          6'h0C: next_op = `FPOD_OP_LOAD_ENVIRONMENT;
          6'h2F: next_op = `FPOD_OP_STORE_STATUS_WORD;
          6'h2E: next_op = `FPOD_OP_SAVE_FULL_STATE;
          6'h2C: next_op = `FPOD_OP_RESTORE_FULL_STATE;
          default: next_op = next_op;
        endcase
        if (next_op >= `FPOD_OP_STORE_STATUS_WORD)
          next_type = `FPOD_TYPE_NONE;
      end else begin
        next_rev = reg_field[0];
        case (reg_field)
          3'h0: next_op = `FPOD_OP_ADD;
          3'h1: next_op = `FPOD_OP_MULTIPLY;
          3'h2: next_op = `FPOD_OP_ORDERED_COMPARE;
          3'h3: begin
            next_op  = `FPOD_OP_ORDERED_COMPARE_POP;
            next_pop = 2'h1;
          end
          3'h4, 3'h5: next_op = `FPOD_OP_SUBTRACT;
          default: next_op = `FPOD_OP_DIVIDE;
        endcase
        if (next_op != `FPOD_OP_SUBTRACT && next_op != `FPOD_OP_DIVIDE)
          next_rev = 1'b0;
      end
    end else begin
      case (low_bits)
        3'h1: begin
          case (opcode_lo_i)
            8'hD0: next_op = `FPOD_OP_NO_OPERATION;
            8'hE0: next_op = `FPOD_OP_NEGATE_SIGN;
            8'hE1: next_op = `FPOD_OP_ABSOLUTE_VALUE;
            8'hE4: next_op = `FPOD_OP_TEST_AGAINST_ZERO;
            8'hE5: next_op = `FPOD_OP_EXAMINE_TOP;
            8'hE8: next_op = `FPOD_OP_LOAD_CONST_ONE;
            8'hE9: next_op = `FPOD_OP_LOAD_LOG2_TEN;
            8'hEA: next_op = `FPOD_OP_LOAD_LOG2_E;
            8'hEB: next_op = `FPOD_OP_LOAD_CONST_PI;
            8'hEC: next_op = `FPOD_OP_LOAD_LOG10_TWO;
            8'hED: next_op = `FPOD_OP_LOAD_LN_TWO;
            8'hEE: next_op = `FPOD_OP_LOAD_CONST_ZERO;
            8'hF0: next_op = `FPOD_OP_EXP2_MINUS_ONE;
            8'hF1: next_op = `FPOD_OP_Y_LOG2_X;
            8'hF2: next_op = `FPOD_OP_PARTIAL_TANGENT;
            8'hF3: next_op = `FPOD_OP_PARTIAL_ARCTANGENT;
            8'hF4: next_op = `FPOD_OP_SPLIT_EXPONENT;
            8'hF5: next_op = `FPOD_OP_STD_PARTIAL_REMAINDER;
            8'hF6: next_op = `FPOD_OP_STACK_PTR_DECREMENT;
            8'hF7: next_op = `FPOD_OP_STACK_PTR_INCREMENT;
            8'hF8: next_op = `FPOD_OP_PARTIAL_REMAINDER;
            8'hF9: next_op = `FPOD_OP_Y_LOG2_X_PLUS_ONE;
            8'hFA: next_op = `FPOD_OP_SQUARE_ROOT;
            8'hFB: next_op = `FPOD_OP_SINE_COSINE;
            8'hFC: next_op = `FPOD_OP_ROUND_INTEGER;
            8'hFD: next_op = `FPOD_OP_SCALE_BY_POWER;
            8'hFE: next_op = `FPOD_OP_SINE;
            8'hFF: next_op = `FPOD_OP_COSINE;
            default: begin
              next_uses_index = 1'b1;
              if (second_hi5 == `FPOD_HI5_LOAD)
                next_op = `FPOD_OP_LOAD_TO_TOP;
              else if (second_hi5 == `FPOD_HI5_EXCHANGE)
                next_op = `FPOD_OP_EXCHANGE_TOP;
            end
          endcase
        end
        3'h5: begin
          next_uses_index = 1'b1;
          case (second_hi5)
            `FPOD_HI5_LOAD: next_op = `FPOD_OP_FREE_REGISTER;
            `FPOD_HI5_STORE: next_op = `FPOD_OP_STORE_TOP;
            `FPOD_HI5_STORE_POP: begin
              next_op  = `FPOD_OP_STORE_TOP_POP;
              next_pop = 2'h1;
            end
            `FPOD_HI5_UCOM: next_op = `FPOD_OP_UNORDERED_COMPARE;
            `FPOD_HI5_UCOM_POP: begin
              next_op  = `FPOD_OP_UNORDERED_COMPARE_POP;
              next_pop = 2'h1;
            end
            default: next_uses_index = 1'b0;
          endcase
        end
        3'h0: begin
          next_uses_index = 1'b1;
          if (second_hi5 == `FPOD_HI5_STORE)
            next_op = `FPOD_OP_ORDERED_COMPARE;
          else if (second_hi5 == `FPOD_HI5_STORE_POP) begin
            next_op  = `FPOD_OP_ORDERED_COMPARE_POP;
            next_pop = 2'h1;
          end
        end
        3'h6: begin
          if (opcode_lo_i == 8'hD9) begin
            next_op  = `FPOD_OP_ORDERED_COMPARE_POP2;
            next_pop = 2'h2;
          end
        end
        3'h2: begin
          if (opcode_lo_i == 8'hE9) begin
            next_op  = `FPOD_OP_UNORDERED_COMPARE_POP2;
            next_pop = 2'h2;
          end
        end
        3'h3: begin
          if (opcode_lo_i == 8'hE3)
            next_op = `FPOD_OP_INITIALISE_UNIT;
          else if (opcode_lo_i == 8'hE2)
            next_op = `FPOD_OP_CLEAR_EXCEPTIONS;
        end
        3'h7: begin
          if (opcode_lo_i == 8'hE0) begin
            next_op  = `FPOD_OP_STORE_STATUS_WORD;
            next_acc = 1'b1;
          end
        end
        default: next_op = `FPOD_OP_INVALID;
      endcase
      // Exact encodings above take priority over the generic d P 0 forms
      if (next_op == `FPOD_OP_INVALID && !low_bits[0]) begin
        next_uses_index = 1'b1;
        next_dir        = low_bits[2];
        next_pop        = {1'b0, low_bits[1]};
        next_rev        = second_hi5[0] ^ low_bits[2];
        if (second_hi5 == `FPOD_HI5_ADD) begin
          next_op  = `FPOD_OP_ADD;
          next_rev = 1'b0;
        end else if (second_hi5 == `FPOD_HI5_MUL) begin
          next_op  = `FPOD_OP_MULTIPLY;
          next_rev = 1'b0;
        end else if (second_hi5[4:1] == `FPOD_HI4_SUB)
          next_op = `FPOD_OP_SUBTRACT;
        else if (second_hi5[4:1] == `FPOD_HI4_DIV)
          next_op = `FPOD_OP_DIVIDE;
      end
    end
    // Unknown encodings carry no side effects to the host
    if (next_op == `FPOD_OP_INVALID) begin
      next_type       = `FPOD_TYPE_NONE;
      next_pop        = 2'h0;
      next_dir        = 1'b0;
      next_rev        = 1'b0;
      next_uses_index = 1'b0;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  // Results hold until the next accepted escape opcode
  always @(posedge ref_clk_i or negedge nrst_sync) begin
    if (!nrst_sync) begin
      valid_o                <= 1'b0;
      invalid_o              <= 1'b0;
      op_o                   <= `FPOD_OP_INVALID;
      class_o                <= `FPOD_CLASS_INVALID;
      is_memory_o            <= 1'b0;
      memory_format_o        <= 2'h0;
      operand_type_o         <= `FPOD_TYPE_NONE;
      stack_register_index_o <= 3'h0;
      direction_o            <= 1'b0;
      pop_count_o            <= 2'h0;
      reverse_o              <= 1'b0;
      to_accumulator_o       <= 1'b0;
    end else begin
      valid_o   <= valid_i & escape_match;
      invalid_o <= valid_i & escape_match & (next_op == `FPOD_OP_INVALID);
      if (valid_i && escape_match) begin
        op_o                   <= next_op;
        class_o                <= class_of(next_op);
        is_memory_o            <= ~register_form & (next_op != `FPOD_OP_INVALID);
        memory_format_o        <= register_form ? 2'h0 : low_bits[2:1];
        operand_type_o         <= next_type;
        stack_register_index_o <= next_uses_index ? stack_index : 3'h0;
        direction_o            <= next_dir;
        pop_count_o            <= next_pop;
        reverse_o              <= next_rev;
        to_accumulator_o       <= next_acc;
      end
    end
  end
endmodule // fpod_decoder

//--- sim/fpod_host_model.sv
// Host core model that presents escape opcodes to the decoder
module fpod_host_model (
  input  wire logic       ref_clk_i,
  input  wire logic       issue_i,
  input  wire logic [7:0] hi_i,
  input  wire logic [7:0] lo_i,
  output logic            valid_o,
  output logic [7:0]      opcode_hi_o,
  output logic [7:0]      opcode_lo_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_hi = 8'h00;
  logic [7:0] last_lo = 8'h00;
  always @(posedge ref_clk_i) begin
    if (issue_i) begin
      last_hi <= hi_i;
      last_lo <= lo_i;
    end
  end
  // Idle bytes show the inverse of the last opcode so a stale value never looks fresh
  assign valid_o     = issue_i;
  assign opcode_hi_o = issue_i ? hi_i : ~last_hi;
  assign opcode_lo_o = issue_i ? lo_i : ~last_lo;
endmodule // fpod_host_model

//--- sim/fpod_decoder_monitor.sv
// Port-level assertions for the escape opcode decoder
`include "fpod_map.vh"
module fpod_decoder_monitor (
  input wire logic       ref_clk_i,
  input wire logic       nrst_i,
  input wire logic       valid_i,
  input wire logic [7:0] opcode_hi_i,
  input wire logic [7:0] opcode_lo_i,
  input wire logic       valid_o,
  input wire logic       invalid_o,
  input wire logic [5:0] op_o,
  input wire logic [2:0] class_o,
  input wire logic       is_memory_o,
  input wire logic [1:0] memory_format_o,
  input wire logic [2:0] stack_register_index_o,
  input wire logic       direction_o,
  input wire logic [1:0] pop_count_o,
  input wire logic       reverse_o,
  input wire logic       to_accumulator_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take = valid_i && (opcode_hi_i[7:3] == `FPOD_ESCAPE);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence taken_s; take; endsequence
  sequence answered_s; valid_o; endsequence
  answer_time_a: assert property (taken_s |=> answered_s)
    else $error("escape opcode not answered after one cycle");
  ignore_other_a: assert property (!take |=> !valid_o)
    else $error("answer without a taken escape opcode");
  invalid_flag_a: assert property (invalid_o |-> valid_o && op_o == `FPOD_OP_INVALID && pop_count_o == 2'h0)
    else $error("invalid flag with a live decode");
  hold_result_a: assert property (!valid_o |-> $stable(op_o) && $stable(class_o))
    else $error("decode result moved without an answer");
  mem_format_a: assert property (valid_o && is_memory_o |-> memory_format_o == $past(opcode_hi_i[2:1]))
    else $error("memory format differs from opcode");
  reg_form_a: assert property (valid_o && $past(opcode_lo_i[7:6]) == `FPOD_MOD_REGISTER |-> !is_memory_o)
    else $error("register form reported as memory");
  direction_pop_a: assert property (valid_o && !is_memory_o && op_o == `FPOD_OP_ADD |->
    direction_o == $past(opcode_hi_i[2]) && pop_count_o == {1'b0, $past(opcode_hi_i[1])})
    else $error("direction or pop differs from opcode");
  reverse_sense_a: assert property (valid_o && !is_memory_o &&
    (op_o == `FPOD_OP_SUBTRACT || op_o == `FPOD_OP_DIVIDE) |->
    reverse_o == ($past(opcode_lo_i[3]) ^ $past(opcode_hi_i[2])))
    else $error("operand order not inverted by direction");
  exchange_index_a: assert property (valid_o && op_o == `FPOD_OP_EXCHANGE_TOP |->
    stack_register_index_o == $past(opcode_lo_i[2:0]))
    else $error("exchange register index wrong");
  accumulator_a: assert property (valid_o && $past(opcode_hi_i) == 8'hDF && $past(opcode_lo_i) == 8'hE0
    |-> to_accumulator_o)
    else $error("status store to accumulator not flagged");
endmodule // fpod_decoder_monitor
bind fpod_decoder fpod_decoder_monitor u_fpod_decoder_monitor (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .valid_i(valid_i), .opcode_hi_i(opcode_hi_i), .opcode_lo_i(opcode_lo_i), .valid_o(valid_o),
  .invalid_o(invalid_o), .op_o(op_o), .class_o(class_o), .is_memory_o(is_memory_o),
  .memory_format_o(memory_format_o), .stack_register_index_o(stack_register_index_o),
  .direction_o(direction_o), .pop_count_o(pop_count_o), .reverse_o(reverse_o),
  .to_accumulator_o(to_accumulator_o));

//--- sim/tb.sv
// Self-checking bench for the escape opcode decoder
`include "fpod_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk_i = 1'b0, nrst_i = 1'b0, issue = 1'b0, valid_i;
  logic [7:0] req_hi = 8'h00, req_lo = 8'h00, opcode_hi_i, opcode_lo_i;
  logic       valid_o, invalid_o, is_memory_o, direction_o, reverse_o, to_accumulator_o;
  logic [5:0] op_o;
  logic [2:0] class_o, operand_type_o, stack_register_index_o;
  logic [1:0] memory_format_o, pop_count_o;
  int         err_count = 0, compares = 0, cycles = 0;
  logic [7:0] one_byte_lo [23] = '{8'hEE, 8'hE8, 8'hEB, 8'hE9, 8'hEA, 8'hEC, 8'hED, 8'hFA, 8'hFD, 8'hF8, 8'hF5,
    8'hFC, 8'hF4, 8'hE1, 8'hE0, 8'hF2, 8'hF3, 8'hFE, 8'hFF, 8'hFB, 8'hF0, 8'hF1, 8'hF9};
  fpod_host_model u_fpod_host_model (.ref_clk_i(ref_clk_i), .issue_i(issue), .hi_i(req_hi), .lo_i(req_lo),
    .valid_o(valid_i), .opcode_hi_o(opcode_hi_i), .opcode_lo_o(opcode_lo_i));
  fpod_decoder u_fpod_decoder (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .valid_i(valid_i),
    .opcode_hi_i(opcode_hi_i), .opcode_lo_i(opcode_lo_i), .valid_o(valid_o), .invalid_o(invalid_o),
    .op_o(op_o), .class_o(class_o), .is_memory_o(is_memory_o), .memory_format_o(memory_format_o),
    .operand_type_o(operand_type_o), .stack_register_index_o(stack_register_index_o),
    .direction_o(direction_o), .pop_count_o(pop_count_o), .reverse_o(reverse_o),
    .to_accumulator_o(to_accumulator_o));
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One opcode, answered on the edge after it is taken
  task automatic t(input logic [7:0] hi, input logic [7:0] lo, input logic [5:0] op, input logic [2:0] cls,
                   input logic [1:0] pop, input logic [2:0] typ);
    @(posedge ref_clk_i);
    issue <= 1'b1;
    req_hi <= hi;
    req_lo <= lo;
    @(posedge ref_clk_i);
    issue <= 1'b0;
    #1;
    chk("valid", 8'h01, {7'h00, valid_o});
    chk("invalid", {7'h00, op == `FPOD_OP_INVALID}, {7'h00, invalid_o});
    chk("op", {2'h0, op}, {2'h0, op_o});
    chk("class", {5'h00, cls}, {5'h00, class_o});
    chk("memory", {7'h00, lo[7:6] != 2'h3 && op != `FPOD_OP_INVALID}, {7'h00, is_memory_o});
    if (op != `FPOD_OP_INVALID) begin
      chk("pop", {6'h00, pop}, {6'h00, pop_count_o});
      chk("type", {5'h00, typ}, {5'h00, operand_type_o});
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    #1;
    chk("reset type", 8'h07, {5'h00, operand_type_o});
    repeat (2) @(posedge ref_clk_i);
    t(8'hD9, 8'h05, 6'h01, 3'h1, 2'h0, 3'h0);
    t(8'hDB, 8'h00, 6'h01, 3'h1, 2'h0, 3'h1);
    t(8'hDF, 8'h28, 6'h01, 3'h1, 2'h0, 3'h4);
    t(8'hDB, 8'h28, 6'h01, 3'h1, 2'h0, 3'h5);
    t(8'hDF, 8'h20, 6'h01, 3'h1, 2'h0, 3'h6);
    t(8'hD9, 8'hC3, 6'h01, 3'h1, 2'h0, 3'h7);
    t(8'hD9, 8'h10, 6'h02, 3'h1, 2'h0, 3'h0);
    t(8'hDD, 8'hD2, 6'h02, 3'h1, 2'h0, 3'h7);
    t(8'hDD, 8'h1C, 6'h03, 3'h1, 2'h1, 3'h2);
    t(8'hDF, 8'h38, 6'h03, 3'h1, 2'h1, 3'h4);
    t(8'hDB, 8'h38, 6'h03, 3'h1, 2'h1, 3'h5);
    t(8'hDF, 8'h30, 6'h03, 3'h1, 2'h1, 3'h6);
    t(8'hDD, 8'hDB, 6'h03, 3'h1, 2'h1, 3'h7);
    t(8'hD9, 8'hC9, 6'h04, 3'h1, 2'h0, 3'h7);
    chk("index", 8'h01, {5'h00, stack_register_index_o});
    t(8'hD8, 8'hD1, 6'h05, 3'h2, 2'h0, 3'h7);
    t(8'hD8, 8'h18, 6'h06, 3'h2, 2'h1, 3'h0);
    t(8'hD8, 8'hD9, 6'h06, 3'h2, 2'h1, 3'h7);
    t(8'hDE, 8'hD9, 6'h07, 3'h2, 2'h2, 3'h7);
    t(8'hDD, 8'hE1, 6'h08, 3'h2, 2'h0, 3'h7);
    t(8'hDD, 8'hE9, 6'h09, 3'h2, 2'h1, 3'h7);
    t(8'hDA, 8'hE9, 6'h0A, 3'h2, 2'h2, 3'h7);
    t(8'hD9, 8'hE4, 6'h0B, 3'h2, 2'h0, 3'h7);
    t(8'hD9, 8'hE5, 6'h0C, 3'h2, 2'h0, 3'h7);
    for (int k = 0; k < 23; k++) begin
      t(8'hD9, one_byte_lo[k], (k < 7) ? 6'(k) + 6'h0D : 6'(k) + 6'h11,
        (k < 7) ? 3'h3 : (k < 15) ? 3'h4 : 3'h5, 2'h0, 3'h7);
    end
    t(8'hDE, 8'h00, 6'h14, 3'h4, 2'h0, 3'h3);
    t(8'hDC, 8'hC1, 6'h14, 3'h4, 2'h0, 3'h7);
    t(8'hDE, 8'hC1, 6'h14, 3'h4, 2'h1, 3'h7);
    t(8'hDC, 8'hE9, 6'h15, 3'h4, 2'h0, 3'h7);
    t(8'hDA, 8'h20, 6'h15, 3'h4, 2'h0, 3'h1);
    t(8'hDC, 8'h38, 6'h17, 3'h4, 2'h0, 3'h2);
    t(8'hD8, 8'hF1, 6'h17, 3'h4, 2'h0, 3'h7);
    t(8'hD8, 8'hC9, 6'h16, 3'h4, 2'h0, 3'h7);
    t(8'hD8, 8'h08, 6'h16, 3'h4, 2'h0, 3'h0);
    t(8'hDB, 8'hE3, 6'h28, 3'h6, 2'h0, 3'h7);
    t(8'hDB, 8'hE2, 6'h2C, 3'h6, 2'h0, 3'h7);
    t(8'hDF, 8'hE0, 6'h29, 3'h6, 2'h0, 3'h7);
    t(8'hD9, 8'h28, 6'h2A, 3'h6, 2'h0, 3'h7);
    t(8'hD9, 8'h38, 6'h2B, 3'h6, 2'h0, 3'h7);
    t(8'hD9, 8'h30, 6'h2D, 3'h6, 2'h0, 3'h7);
    t(8'hD9, 8'h20, 6'h2E, 3'h6, 2'h0, 3'h7);
    t(8'hDD, 8'h38, 6'h29, 3'h6, 2'h0, 3'h7);
    t(8'hDD, 8'h30, 6'h2F, 3'h6, 2'h0, 3'h7);
    t(8'hDD, 8'h20, 6'h30, 3'h6, 2'h0, 3'h7);
    t(8'hD9, 8'hF7, 6'h31, 3'h6, 2'h0, 3'h7);
    t(8'hD9, 8'hF6, 6'h32, 3'h6, 2'h0, 3'h7);
    t(8'hDD, 8'hC2, 6'h33, 3'h6, 2'h0, 3'h7);
    t(8'hD9, 8'hD0, 6'h34, 3'h6, 2'h0, 3'h7);
    @(posedge ref_clk_i);
    issue <= 1'b1;
    req_hi <= 8'hC9;
    @(posedge ref_clk_i);
    issue <= 1'b0;
    #1;
    chk("non escape", 8'h00, {7'h00, valid_o});
    chk("kept op", 8'h34, {2'h0, op_o});
    t(8'hD9, 8'hD1, 6'h00, 3'h0, 2'h0, 3'h7);
    close_out();
  end
endmodule // tb
